// ==== testbench.sv ====
// Self-checking bench: reader end and tag end joined by the link
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tvr_pkg::*;

  logic        core_clk;
  logic        nrst;
  logic [31:0] page_data;
  logic [7:0]  page_addr;
  logic [7:0]  protect_start_page;
  logic        authenticated;
  logic        limit_reached;
  logic        nvm_fail;
  logic        tear_fail;
  logic        busy;
  logic        req_go;
  tvr_cmd_t    req_cmd;
  logic [1:0]  req_len;
  logic        req_bad_crc;
  logic        ans_valid;
  logic [7:0]  ans_data;
  logic        ans_code;
  logic        ans_done;
  logic        ans_timeout;
  logic        ready;
  logic [31:0] mem [NUM_PAGES];
  logic [31:0] seed;
  logic [7:0]  rx [$];
  logic [7:0]  exp_q [$];
  logic [7:0]  pg;
  int          n_mismatch;
  int          checked;
  int          n_timeout;
  int          p;
  int          b;

  tvr_link_if link ();

  tvr_tag i_tvr_tag (.core_clk(core_clk), .nrst(nrst), .link(link.tag),
    .page_data(page_data), .page_addr(page_addr),
    .protect_start_page(protect_start_page),
    .authenticated(authenticated), .limit_reached(limit_reached),
    .nvm_fail(nvm_fail), .tear_fail(tear_fail), .busy(busy));
  tvr_rdr i_tvr_rdr (.core_clk(core_clk), .nrst(nrst), .link(link.rdr),
    .req_go(req_go), .req_cmd(req_cmd), .req_len(req_len),
    .req_bad_crc(req_bad_crc), .ans_valid(ans_valid), .ans_data(ans_data),
    .ans_code(ans_code), .ans_done(ans_done), .ans_timeout(ans_timeout),
    .ready(ready));
  tvr_link_asserts i_tvr_link_asserts (.core_clk(core_clk), .nrst(nrst),
    .rq_sof(link.rq_sof), .rq_valid(link.rq_valid),
    .rq_data(link.rq_data), .rq_eof(link.rq_eof),
    .rq_crc_err(link.rq_crc_err), .rs_sof(link.rs_sof),
    .rs_valid(link.rs_valid), .rs_data(link.rs_data),
    .rs_short(link.rs_short), .rs_eof(link.rs_eof));

  // Page store; addresses past the end read as zero
  assign page_data = (page_addr < 8'(NUM_PAGES)) ? mem[page_addr[5:0]] : '0;

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Sampled on the falling edge, clear of flop updates
  // Answer bytes are taken from the reader's user side
  always @(negedge core_clk)
  begin
    if (ans_valid === 1'b1)
      rx.push_back(ans_data);
    if (ans_timeout === 1'b1)
      n_timeout++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Bitwise reflected form, kept apart from the design's byte-step function
  function automatic logic [15:0] crc_a(input logic [15:0] c,
                                        input logic [7:0]  d);
    c = c ^ {8'h00, d};
    for (int k = 0; k < 8; k++)
      c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    crc_a = c;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic add_crc();
    logic [15:0] c;
    c = CRC_INIT[15:0];
    foreach (exp_q[k])
      c = crc_a(c, exp_q[k]);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
  endtask

  // Page sent at slot p of a read: wraps to zero after the last page
  function automatic logic [7:0] rd_page(input logic [7:0] start,
                                         input logic [7:0] last,
                                         input int p);
    int q;
    q = int'(start) + p;
    if (q > int'(last))
      q = q - int'(last) - 1;
    rd_page = 8'(q);
  endfunction

  // Bounded wait at falling edges for ready (0) or the answer's end (1)
  task automatic wait_hi(input bit done);
    int k;
    for (k = 0; k < 30000 && (done ? ans_done : ready) !== 1'b1; k++)
      @(negedge core_clk);
    if (k == 30000)
    begin
      n_mismatch++;
      $display("BAD %0t no answer", $time);
      results();
    end
  endtask

  // One command: wait for ready, pulse go, wait for the answer
  task automatic run(input logic [7:0] cmd, input logic [7:0] arg,
                     input logic [1:0] len, input logic bad);
    wait_hi(1'b0);
    rx.delete();
    req_cmd = {cmd, arg};
    req_len = len;
    req_bad_crc = bad;
    req_go = 1'b1;
    @(negedge core_clk);
    req_go = 1'b0;
    @(negedge core_clk);
    check({31'h0, busy}, 32'h1);
    wait_hi(1'b1);
    @(negedge core_clk);
    check({31'h0, busy}, 32'h0);
  endtask

  task automatic cmp();
    check(32'(rx.size()), 32'(exp_q.size()));
    for (int k = 0; k < exp_q.size() && k < rx.size(); k++)
      check({24'h0, rx[k]}, {24'h0, exp_q[k]});
    check({31'h0, ans_code}, 32'h0);
  endtask

  initial
  begin
    nrst = 1'b0;
    req_go = 1'b0;
    req_cmd = '0;
    req_len = 2'd1;
    req_bad_crc = 1'b0;
    protect_start_page = 8'h2C;
    authenticated = 1'b0;
    limit_reached = 1'b0;
    nvm_fail = 1'b0;
    tear_fail = 1'b0;
    seed = 32'hb115;
    for (int k = 0; k < NUM_PAGES; k++)
    begin
      seed = lfsr(seed);
      mem[k] = seed;
    end
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    // Version query, one command byte only
    exp_q = {VER_HEADER, VER_VENDOR, VER_TYPE, VER_SUBTYPE, VER_MAJOR,
             VER_MINOR, VER_STORAGE, VER_PROTO};
    add_crc();
    run(CMD_VERSION, 8'h00, 2'd1, 1'b0);
    cmp();
    $display("test 1 done");
    // Read just below protection: wraps early, password page zeroed
    exp_q.delete();
    for (p = 0; p < 4; p++)
    begin
      pg = rd_page(8'h2A, protect_start_page - 8'd1, p);
      for (b = 0; b < 4; b++)
        exp_q.push_back((pg == PWD_PAGE || pg == PASSWORD_ACK_VALUE_PAGE) ? 8'h00 :
                        mem[pg[5:0]][8*b +: 8]);
    end
    add_crc();
    run(CMD_READ, 8'h2A, 2'd2, 1'b0);
    cmp();
    $display("test 2 done");
    // Reset in mid-run cuts the quiet time and idles both ends
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    check({31'h0, ready}, 32'h1);
    check({31'h0, busy}, 32'h0);
    nrst = 1'b1;
    // Corrupted read to a bad page: CRC refusal outranks address
    run(CMD_READ, 8'h3C, 2'd2, 1'b1);
    check(32'(rx.size()), 32'd1);
    check({28'h0, rx[0][3:0]}, {28'h0, NAK_CRC});
    check({31'h0, ans_code}, 32'h1);
    check(32'(n_timeout), 32'h0);
    $display("test 3 done");
    results();
  end
endmodule

// ==== tvr_link_asserts.sv ====
// Checker for frame timing and answer shapes on the tag link
module tvr_link_asserts
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // Reader to tag
  input wire logic       rq_sof,
  input wire logic       rq_valid,
  input wire logic [7:0] rq_data,
  input wire logic       rq_eof,
  input wire logic       rq_crc_err,
  // Tag to reader
  input wire logic       rs_sof,
  input wire logic       rs_valid,
  input wire logic [7:0] rs_data,
  input wire logic       rs_short,
  input wire logic       rs_eof
);
  timeunit 1ns;
  timeprecision 1ps;
  import tvr_pkg::*;
  logic [23:0] wait_q;   // edges since reader frame end
  logic [23:0] gap_q;    // edges since tag frame end
  logic        armed_q;
  logic        rq_in_q;
  logic        first_q;
  logic        crc_q;
  logic [7:0]  cmd_q;
  logic [4:0]  nb_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Frame trackers; gap saturates so long idle never wraps
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_q  <= '0;
      gap_q   <= 24'(GAP_CYC);
      armed_q <= 1'b0;
      rq_in_q <= 1'b0;
      first_q <= 1'b0;
      crc_q   <= 1'b0;
      cmd_q   <= '0;
      nb_q    <= '0;
    end
    else
    begin
      wait_q  <= rq_eof ? 24'd1 : wait_q + 24'(armed_q);
      armed_q <= rq_eof | (armed_q & ~rs_sof);
      gap_q   <= rs_eof ? 24'd1 : gap_q + 24'(gap_q < 24'(GAP_CYC));
      rq_in_q <= rq_sof | (rq_in_q & ~rq_eof);
      first_q <= rq_sof | (first_q & ~rq_valid);
      crc_q   <= rq_eof ? rq_crc_err : crc_q;
      cmd_q   <= (rq_valid && first_q) ? rq_data : cmd_q;
      nb_q    <= rs_sof ? 5'(rs_valid) : nb_q + 5'(rs_valid);
    end
  end

  AST_FDT_MIN: assert property (
    rs_sof |-> armed_q && wait_q >= FDT_MIN_CYC)
    else $error("tag answer sent before frame delay");
  AST_TIMEOUT: assert property (
    armed_q |-> wait_q <= TIMEOUT_CYC)
    else $error("tag answer missing after timeout");
  // One cycle of slack: the gap figure is itself rounded
  AST_GAP: assert property (rq_sof |-> gap_q >= GAP_CYC - 1)
    else $error("reader frame too soon after tag frame");
  AST_RQ_FRAME: assert property (rq_valid |-> rq_in_q)
    else $error("reader byte outside frame");
  AST_NAK_CRC: assert property (
    rs_sof && crc_q |-> rs_short && rs_valid && rs_data[3:0] == NAK_CRC)
    else $error("bad reader frame not refused with 1h");
  AST_SHORT: assert property (
    rs_sof && rs_short |-> rs_valid ##1 !rs_valid [*2])
    else $error("code frame not a single unit");
  AST_LEN: assert property (
    rs_eof && !rs_short |->
    (nb_q + 5'(rs_valid)) inside {5'd1, 5'd2, 5'd10, 5'd18})
    else $error("data frame length wrong");
  AST_VERSION: assert property (
    rs_sof && !rs_short && cmd_q == CMD_VERSION
    |=> rs_data == VER_HEADER ##6 rs_data == VER_STORAGE
    ##1 rs_data == VER_PROTO)
    else $error("version bytes out of order");
endmodule

// ==== tvr_link_if.sv ====
// Byte-framed link joining the reader end and the tag end
interface tvr_link_if;
  logic       rq_sof;
  logic       rq_valid;
  logic [7:0] rq_data;
  logic       rq_eof;
  logic       rq_crc_err;
  logic       rs_sof;
  logic       rs_valid;
  logic [7:0] rs_data;
  logic       rs_short;
  logic       rs_eof;
  modport tag (input rq_sof, rq_valid, rq_data, rq_eof, rq_crc_err,
               output rs_sof, rs_valid, rs_data, rs_short, rs_eof);
  modport rdr (output rq_sof, rq_valid, rq_data, rq_eof, rq_crc_err,
               input rs_sof, rs_valid, rs_data, rs_short, rs_eof);
endinterface

// ==== tvr_pkg.sv ====
// Shared constants and types for the tag responder and reader ends
package tvr_pkg;
  // Command bytes
  localparam logic [7:0] CMD_REQ     = 8'h26;
  localparam logic [7:0] CMD_WUP     = 8'h52;
  localparam logic [7:0] CMD_SEL2    = 8'h95;
  localparam logic [7:0] CMD_VERSION = 8'h60;
  localparam logic [7:0] CMD_READ    = 8'h30;
  // Four-bit answers
  localparam logic [3:0] ACK_CODE     = 4'hA;
  localparam logic [3:0] NAK_ARG      = 4'h0;
  localparam logic [3:0] NAK_CRC      = 4'h1;
  localparam logic [3:0] NAK_LIMIT    = 4'h4;
  localparam logic [3:0] NAK_NVM      = 4'h5;
  localparam logic [3:0] NAK_TEAR     = 4'h6;
  localparam logic [3:0] NAK_NVM_ALT  = 4'h7;
  // Activation answers
  localparam logic [7:0] ATQA_LO = 8'h44;
  localparam logic [7:0] ATQA_HI = 8'h00;
  localparam logic [7:0] SAK_VAL = 8'h00;
  // Version reply; identity bytes are arbitrary neutral values
  localparam logic [7:0] VER_HEADER  = 8'h00;
  localparam logic [7:0] VER_VENDOR  = 8'h5A;
  localparam logic [7:0] VER_TYPE    = 8'h11;
  localparam logic [7:0] VER_SUBTYPE = 8'h22;
  localparam logic [7:0] VER_MAJOR   = 8'h01;
  localparam logic [7:0] VER_MINOR   = 8'h01;
  localparam logic [7:0] VER_STORAGE = 8'h0F;
  localparam logic [7:0] VER_PROTO   = 8'h03;
  // Memory layout
  localparam logic [7:0] LAST_PAGE  = 8'h3B;
  localparam int         NUM_PAGES  = 60;
  localparam logic [7:0] PWD_PAGE   = 8'h2B;
  localparam logic [7:0] PASSWORD_ACK_VALUE_PAGE  = 8'h2C;
  localparam int         VER_LEN    = 8;
  localparam int         READ_LEN   = 16;
  // Timing at 250 MHz
  localparam int CLK_MHZ      = 250;
  localparam int FC_KHZ       = 13560;
  localparam int FDT_N        = 9;
  // Least delay n*128+84 carrier cycles, rounded up to core cycles
  localparam int FDT_MIN_CYC  =
    ((FDT_N * 128 + 84) * CLK_MHZ * 1000 + FC_KHZ - 1) / FC_KHZ;
  localparam int GAP_US       = 87;
  localparam int GAP_CYC      = GAP_US * CLK_MHZ;
  localparam int TIMEOUT_MS   = 5;
  localparam int TIMEOUT_CYC  = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int CRC_INIT     = 16'h6363;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] arg;
  } tvr_cmd_t;

  // Type A CRC, one byte step
  function automatic logic [15:0] tvr_crc(input logic [15:0] c,
                                         input logic [7:0] b);
    logic [7:0] t;
    t = b ^ c[7:0];
    t = t ^ {t[3:0], 4'h0};
    tvr_crc = {8'h00, c[15:8]} ^ {t, 8'h00} ^ {5'h00, t, 3'h0}
              ^ {12'h000, t[7:4]};
  endfunction
endpackage

// ==== tvr_rdr.sv ====
// Reader end: sends one command frame and collects the answer
module tvr_rdr
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // Link
  tvr_link_if.rdr           link,
  // User side request
  input  wire logic         req_go,
  input  wire tvr_pkg::tvr_cmd_t req_cmd,
  input  wire logic [1:0]   req_len,
  input  wire logic         req_bad_crc,
  // User side answer
  output logic              ans_valid,
  output logic [7:0]        ans_data,
  output logic              ans_code,
  output logic              ans_done,
  output logic              ans_timeout,
  output logic              ready
);
  import tvr_pkg::*;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b00, RS_SEND = 2'b01, RS_WAIT = 2'b11, RS_GAP = 2'b10
  } tvr_rdr_st_t;

  typedef struct packed {
    tvr_rdr_st_t st;
    tvr_cmd_t    cmd;
    logic [1:0]  len;
    logic [1:0]  idx;
    logic        bad;
    logic [20:0] cnt;
    logic        sof;
    logic        vld;
    logic [7:0]  dat;
    logic        eof;
    logic        err;
    logic        a_vld;
    logic [7:0]  a_dat;
    logic        a_code;
    logic        a_done;
    logic        a_to;
    logic        rdy;
  } tvr_rdr_s_t;

  tvr_rdr_s_t s_q, s_d;

  // Next-state process
  always_comb
  begin
    s_d        = s_q;
    s_d.sof    = 1'b0;
    s_d.vld    = 1'b0;
    s_d.eof    = 1'b0;
    s_d.a_vld  = 1'b0;
    s_d.a_done = 1'b0;
    s_d.a_to   = 1'b0;
    s_d.err    = 1'b0;
    case (s_q.st)
      RS_IDLE:
        if (req_go)
        begin
          s_d.st  = RS_SEND;
          s_d.cmd = req_cmd;
          s_d.len = (req_len == 2'd0) ? 2'd1 : req_len;
          s_d.bad = req_bad_crc;
          s_d.idx = 2'd0;
          s_d.sof = 1'b1;                                 // see [R4]
          s_d.rdy = 1'b0;
        end
      RS_SEND:
      begin
        s_d.vld = 1'b1;
        s_d.dat = (s_q.idx == 2'd0) ? s_q.cmd.cmd : s_q.cmd.arg;
        s_d.idx = s_q.idx + 2'd1;
        if (s_q.idx == s_q.len - 2'd1)
        begin
          s_d.st  = RS_WAIT;
          s_d.eof = 1'b1;                                 // see [R4]
          s_d.err = s_q.bad;
          s_d.cnt = 21'd0;
        end
      end
      RS_WAIT:
      begin
        // Give up when no answer comes in time
        s_d.cnt = s_q.cnt + 21'd1;
        if (link.rs_valid)
        begin
          s_d.a_vld  = 1'b1;
          s_d.a_dat  = link.rs_data;
          s_d.a_code = link.rs_short;
        end
        if (link.rs_eof)
        begin
          s_d.a_done = 1'b1;
          s_d.st     = RS_GAP;
          s_d.cnt    = 21'd0;
        end
        else if (s_q.cnt == 21'(TIMEOUT_CYC - 1))         // see [R3]
        begin
          s_d.a_to = 1'b1;
          s_d.st   = RS_GAP;
          s_d.cnt  = 21'd0;
        end
      end
      RS_GAP:
      begin
        // Keep the least quiet time before the next command
        s_d.cnt = s_q.cnt + 21'd1;
        if (s_q.cnt == 21'(GAP_CYC - 1))                  // see [R1]
        begin
          s_d.st  = RS_IDLE;
          s_d.rdy = 1'b1;
        end
      end
      default: s_d.st = RS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q     <= '0;
      s_q.rdy <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign link.rq_sof     = s_q.sof;
  assign link.rq_valid   = s_q.vld;
  assign link.rq_data    = s_q.dat;
  assign link.rq_eof     = s_q.eof;
  assign link.rq_crc_err = s_q.err;
  assign ans_valid       = s_q.a_vld;
  assign ans_data        = s_q.a_dat;
  assign ans_code        = s_q.a_code;
  assign ans_done        = s_q.a_done;
  assign ans_timeout     = s_q.a_to;
  assign ready           = s_q.rdy;
endmodule

// ==== tvr_tag.sv ====
// Tag end: decodes reader frames and sends answers
// Summary of operation
// [R1] Reader waits 87 us after tag frames
// [R2] Answer no sooner than frame delay n=9
// [R3] Answer within 5 ms
// [R4] Reader frames: start bit, zero, idle bit
// [R5] Tag frames: start bit, idle end bit
// [R6] Single 4-bit codes, Ah is acknowledge
// [R7] 0h bad argument, 1h parity/CRC error
// [R8] 4h on counter overflow or limit
// [R9] 5h/7h write failure, 6h tearing corruption
// [R10] Request/wake-up answers 44h first
// [R11] Level-two select answers all-zero byte
// [R12] Answer bits 7,8 give fixed size
// [R13] Version 60h returns 8 bytes plus CRC
// [R14] Version bytes in fixed documented order
// [R15] Storage byte: exponent, low bit range
// [R16] Read 30h returns four pages plus CRC
// [R17] Start page above 3Bh refused
// [R18] Reads wrap from 3Bh to page zero
// [R19] Protected start page refused unauthenticated
// [R20] Unauthenticated reads wrap before protection
// [R21] Authenticated reads ignore protection
// [R22] Password pages read as zero
// [R23] Protection only with in-range start page
// [R24] CRC on data frames, not codes; activation answers are sent without one
module tvr_tag
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // Link
  tvr_link_if.tag           link,
  // Memory address out, page data and state inputs from the tag core
  input  wire logic [31:0]  page_data,
  output logic      [7:0]   page_addr,
  input  wire logic [7:0]   protect_start_page,
  input  wire logic         authenticated,
  input  wire logic         limit_reached,
  input  wire logic         nvm_fail,
  input  wire logic         tear_fail,
  // Status
  output logic              busy
);
  import tvr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_CMD = 3'b001, ST_WAIT = 3'b011,
    ST_SEND = 3'b010, ST_CRC = 3'b110
  } tvr_state_t;

  typedef struct packed {
    tvr_state_t  st;
    tvr_cmd_t    req;
    logic [1:0]  nbytes;
    logic [15:0] cnt;
    logic [4:0]  idx;
    logic [4:0]  len;
    logic        code;
    logic [3:0]  code_val;
    logic [7:0]  limit;
    logic [15:0] crc;
    logic [7:0]  paddr;
    logic        sof;
    logic        vld;
    logic [7:0]  dat;
    logic        shrt;
    logic        eof;
    logic        bsy;
  } tvr_tag_st_t;

  tvr_tag_st_t s_q, s_d;

  // Byte to send at index i; pages come from page_data in order
  function automatic logic [7:0] pick_byte(input tvr_cmd_t r,
                                           input logic [4:0] i,
                                           input logic [31:0] pd,
                                           input logic [7:0] pg);
    logic [7:0] v;
    v = 8'h00;
    case (r.cmd)
      CMD_REQ, CMD_WUP: v = (i == 5'd0) ? ATQA_LO : ATQA_HI; // see [R10] [R12]
      CMD_SEL2:         v = SAK_VAL;                          // see [R11]
      CMD_VERSION:                                      // see [R14] [R15]
        case (i[2:0])
          3'd0:    v = VER_HEADER;
          3'd1:    v = VER_VENDOR;
          3'd2:    v = VER_TYPE;
          3'd3:    v = VER_SUBTYPE;
          3'd4:    v = VER_MAJOR;
          3'd5:    v = VER_MINOR;
          3'd6:    v = VER_STORAGE;
          default: v = VER_PROTO;
        endcase
      default:
        if (pg == PWD_PAGE || pg == PASSWORD_ACK_VALUE_PAGE) v = 8'h00;     // see [R22]
        else v = pd[8*i[1:0] +: 8];
    endcase
    pick_byte = v;
  endfunction

  logic [7:0] nxt_byte;
  logic       prot_on;

  always_comb
  begin
    // Protection needs an in-range start page and no authentication
    prot_on  = (protect_start_page <= LAST_PAGE) &&
               !authenticated;                        // see [R23] [R21]
    nxt_byte = pick_byte(s_q.req, s_q.idx, page_data, s_q.paddr);
  end

  // Whole-state next-value process
  always_comb
  begin
    s_d     = s_q;
    s_d.sof = 1'b0;
    s_d.vld = 1'b0;
    s_d.eof = 1'b0;
    case (s_q.st)
      ST_IDLE:
      begin
        if (link.rq_sof)
        begin
          s_d.st     = ST_CMD;
          s_d.nbytes = 2'd0;
          s_d.bsy    = 1'b1;
        end
      end
      ST_CMD:
      begin
        if (link.rq_valid)
        begin
          if (s_q.nbytes == 2'd0) s_d.req.cmd = link.rq_data;
          else if (s_q.nbytes == 2'd1) s_d.req.arg = link.rq_data;
          if (s_q.nbytes != 2'd3) s_d.nbytes = s_q.nbytes + 2'd1;
        end
        if (link.rq_eof)
        begin
          s_d.st    = ST_WAIT;
          s_d.cnt   = 16'h0000;
          s_d.idx   = 5'd0;
          s_d.code  = 1'b0;
          s_d.limit = LAST_PAGE;
          s_d.crc   = CRC_INIT[15:0];
          // The last byte comes with the frame end: decode the new copy
          s_d.paddr = s_d.req.arg;
          // Command decode and refusals
          if (link.rq_crc_err)
          begin
            s_d.code = 1'b1;
            s_d.code_val = NAK_CRC;                       // see [R7]
          end
          else
            case (s_d.req.cmd)
              CMD_REQ, CMD_WUP: s_d.len = 5'd2;
              CMD_SEL2:         s_d.len = 5'd1;
              CMD_VERSION:      s_d.len = 5'(VER_LEN);    // see [R13]
              CMD_READ:
              begin
                s_d.len = 5'(READ_LEN);                   // see [R16]
                if (limit_reached)
                begin
                  s_d.code = 1'b1;
                  s_d.code_val = NAK_LIMIT;               // see [R8]
                end
                else if (tear_fail)
                begin
                  s_d.code = 1'b1;
                  s_d.code_val = NAK_TEAR;                // see [R9]
                end
                else if (nvm_fail)
                begin
                  s_d.code = 1'b1;
                  s_d.code_val = NAK_NVM;                 // see [R9]
                end
                else if (s_d.req.arg > LAST_PAGE ||
                         (prot_on && s_d.req.arg >= protect_start_page))
                begin
                  s_d.code = 1'b1;
                  s_d.code_val = NAK_ARG;              // see [R7] [R17] [R19]
                end
                if (prot_on)
                  s_d.limit = protect_start_page - 8'd1;  // see [R20]
              end
              default:
              begin
                s_d.code = 1'b1;
                s_d.code_val = NAK_ARG;                   // see [R6]
              end
            endcase
        end
      end
      ST_WAIT:
      begin
        // Hold off the least frame delay before answering
        s_d.cnt = s_q.cnt + 16'd1;
        if (s_q.cnt == 16'(FDT_MIN_CYC - 1))              // see [R2] [R3]
        begin
          s_d.st   = s_q.code ? ST_CRC : ST_SEND;
          s_d.sof  = 1'b1;                                // see [R5]
          s_d.shrt = s_q.code;
          if (s_q.code)
          begin
            s_d.vld = 1'b1;
            s_d.dat = {4'h0, s_q.code_val};               // see [R6]
          end
        end
      end
      ST_SEND:
      begin
        s_d.vld = 1'b1;
        s_d.dat = nxt_byte;
        if (s_q.req.cmd == CMD_REQ || s_q.req.cmd == CMD_WUP ||
            s_q.req.cmd == CMD_SEL2)
          s_d.crc = CRC_INIT[15:0];
        else
          s_d.crc = tvr_crc(s_q.crc, nxt_byte);           // see [R24]
        s_d.idx = s_q.idx + 5'd1;
        if (s_q.idx[1:0] == 2'd3)
          s_d.paddr = (s_q.paddr >= s_q.limit) ? 8'h00
                      : s_q.paddr + 8'd1;                 // see [R18] [R20]
        if (s_q.idx == s_q.len - 5'd1)
        begin
          s_d.st  = ST_CRC;
          s_d.idx = 5'd0;
        end
      end
      ST_CRC:
      begin
        // Codes and activation answers carry no checksum
        if (!s_q.code && s_q.idx != 5'd2 &&
            (s_q.req.cmd == CMD_VERSION || s_q.req.cmd == CMD_READ))
        begin
          s_d.vld = 1'b1;
          s_d.dat = (s_q.idx == 5'd0) ? s_q.crc[7:0] : s_q.crc[15:8];
          s_d.idx = s_q.idx + 5'd1;
        end
        else
        begin
          s_d.eof = 1'b1;                                 // see [R5]
          s_d.bsy = 1'b0;
          s_d.st  = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q       <= '0;
      s_q.limit <= LAST_PAGE;
    end
    else
      s_q <= s_d;
  end

  assign link.rs_sof   = s_q.sof;
  assign link.rs_valid = s_q.vld;
  assign link.rs_data  = s_q.dat;
  assign link.rs_short = s_q.shrt;
  assign link.rs_eof   = s_q.eof;
  assign page_addr     = s_q.paddr;
  assign busy          = s_q.bsy;
endmodule
